/* verilog/qsc_pkg.sv */
// Package holding register map, field layout and reset values of the scheduler configuration bank
package qsc_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_HIT_STREAK = 8'h2c;
  localparam logic [7:0] OFF_CLASS_THR = 8'h30;
  localparam logic [7:0] OFF_ESCALATE = 8'h34;
  localparam logic [7:0] OFF_PRIO_LO = 8'h38;
  localparam logic [7:0] OFF_PRIO_HI = 8'h3c;
  localparam logic [7:0] OFF_TMO_LO = 8'h40;
  localparam logic [7:0] OFF_TMO_PRESC = 8'h48;

  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_HIT_STREAK = 32'h08909fbf;
  localparam logic [31:0] RST_CLASS_THR = 32'h00000fc8;
  localparam logic [31:0] RST_ESCALATE = 32'h00080000;
  localparam logic [31:0] RST_PRIO_LO = 32'h76543210;
  localparam logic [31:0] RST_PRIO_HI = 32'hfedcba98;
  localparam logic [31:0] RST_TMO_LO = 32'h00000000;
  localparam logic [31:0] RST_TMO_PRESC = 32'h00000001;

  // ==========================================================
  // Writable bit masks, reserved bits read as zero
  localparam logic [31:0] MSK_HIT_STREAK = 32'hbfbfbfbf;
  localparam logic [31:0] MSK_CLASS_THR = 32'h00000fff;
  localparam logic [31:0] MSK_ESCALATE = 32'h000f0f03;
  localparam logic [31:0] MSK_FULL = 32'hffffffff;
  localparam logic [31:0] MSK_TMO_PRESC = 32'h00000003;

  // ==========================================================
  // Field positions
  localparam int unsigned CLASS_SLOT_W = 8;
  localparam int unsigned FAVOUR_BIT = 7;
  localparam int unsigned CAP_LSB = 0;
  localparam int unsigned CAP_W = 6;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned THR_TOP_LSB = 8;
  localparam int unsigned THR_HIGH_LSB = 4;
  localparam int unsigned THR_MED_LSB = 0;
  localparam int unsigned BACKLOG_LSB = 16;
  localparam int unsigned ESC_CNT_LSB = 8;
  localparam int unsigned ESC_PRESC_LSB = 0;
  localparam int unsigned PRESC_W = 2;

  typedef enum logic [1:0] {
    QSC_LOW = 2'b00,
    QSC_MEDIUM = 2'b01,
    QSC_HIGH = 2'b10,
    QSC_TOP = 2'b11
  } qsc_class_t;

endpackage

/* verilog/qsc_cfg_if.sv */
// Interface carrying the applied configuration to the request classifier
`timescale 1ns/1ps
interface qsc_cfg_if;
  logic [31:0] hit_streak;
  logic [31:0] class_thr;
  logic [31:0] prio_lo;
  logic [31:0] prio_hi;
  logic [31:0] tmo_lo;
  modport src (output hit_streak, class_thr, prio_lo, prio_hi, tmo_lo);
  modport dst (input hit_streak, class_thr, prio_lo, prio_hi, tmo_lo);
endinterface

/* verilog/qsc_classify.sv */
// Classifier mapping a request service value onto class, priority and timeout
`timescale 1ns/1ps
module qsc_classify (
  input wire logic clk_i,
  input wire logic rst_i,
  qsc_cfg_if.dst cfg,
  input wire logic req_valid_i,
  input wire logic [3:0] request_service_value_i,
  output qsc_pkg::qsc_class_t req_class_o,
  output logic [3:0] per_value_queue_priority_o,
  output logic [3:0] per_value_promotion_timeout_o,
  output logic timeout_promote_en_o,
  output logic row_hit_favour_o,
  output logic [5:0] row_streak_cap_o,
  output logic row_streak_cap_en_o,
  output logic result_valid_o
);
  import qsc_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [3:0] nib(input logic [31:0] w, input logic [2:0] idx);
    nib = w[{idx, 2'b00} +: NIB_W];
  endfunction

  function automatic qsc_class_t classify(input logic [31:0] thr, input logic [3:0] v);
    if (v >= thr[THR_TOP_LSB +: NIB_W]) begin
      classify = QSC_TOP;
    end else if (v >= thr[THR_HIGH_LSB +: NIB_W]) begin
      classify = QSC_HIGH;
    end else if (v >= thr[THR_MED_LSB +: NIB_W]) begin
      classify = QSC_MEDIUM;
    end else begin
      classify = QSC_LOW;
    end
  endfunction

  // ==========================================================
  // Lookup
  qsc_class_t class_reg, class_next;
  logic [3:0] prio_reg, prio_next, tmo_reg, tmo_next;
  logic tmo_en_reg, tmo_en_next, fav_reg, fav_next, cap_en_reg, cap_en_next, valid_reg, valid_next;
  logic [5:0] cap_reg, cap_next;
  logic [7:0] slot;

  always_comb begin
    class_next = classify(cfg.class_thr, request_service_value_i);
    slot = cfg.hit_streak[{class_next, 3'b000} +: CLASS_SLOT_W];
    fav_next = slot[FAVOUR_BIT];
    cap_next = slot[CAP_LSB +: CAP_W];
    cap_en_next = (cap_next != 6'h00);
    prio_next = request_service_value_i[3] ? nib(cfg.prio_hi, request_service_value_i[2:0])
                                           : nib(cfg.prio_lo, request_service_value_i[2:0]);
    tmo_next = request_service_value_i[3] ? 4'h0 : nib(cfg.tmo_lo, request_service_value_i[2:0]);
    tmo_en_next = (tmo_next != 4'h0);
    valid_next = req_valid_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      class_reg <= QSC_LOW;
      prio_reg <= 4'h0;
      tmo_reg <= 4'h0;
      tmo_en_reg <= 1'b0;
      fav_reg <= 1'b0;
      cap_reg <= 6'h00;
      cap_en_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      class_reg <= class_next;
      prio_reg <= prio_next;
      tmo_reg <= tmo_next;
      tmo_en_reg <= tmo_en_next;
      fav_reg <= fav_next;
      cap_reg <= cap_next;
      cap_en_reg <= cap_en_next;
      valid_reg <= valid_next;
    end
  end

  assign req_class_o = class_reg;
  assign per_value_queue_priority_o = prio_reg;
  assign per_value_promotion_timeout_o = tmo_reg;
  assign timeout_promote_en_o = tmo_en_reg;
  assign row_hit_favour_o = fav_reg;
  assign row_streak_cap_o = cap_reg;
  assign row_streak_cap_en_o = cap_en_reg;
  assign result_valid_o = valid_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_class_top: assert property (
    request_service_value_i >= cfg.class_thr[11:8] |=> req_class_o == QSC_TOP)
    else $error("top class not chosen");
  chk_class_low: assert property (
    request_service_value_i < cfg.class_thr[3:0] && request_service_value_i < cfg.class_thr[7:4]
    && request_service_value_i < cfg.class_thr[11:8] |=> req_class_o == QSC_LOW)
    else $error("low class not chosen");
  chk_cap_zero_off: assert property (
    row_streak_cap_o == 6'h00 |-> !row_streak_cap_en_o)
    else $error("zero cap still enabled");
  chk_tmo_zero_off: assert property (
    timeout_promote_en_o == (per_value_promotion_timeout_o != 4'h0))
    else $error("timeout enable wrong");
  chk_prio_lookup: assert property (
    request_service_value_i == 4'h9 |=> per_value_queue_priority_o == $past(cfg.prio_hi[7:4]))
    else $error("priority lookup wrong");
  cov_top_class: cover property (result_valid_o && req_class_o == QSC_TOP);
  cov_tmo_on: cover property (result_valid_o && timeout_promote_en_o);
endmodule

/* verilog/qsc_top.sv */
// Scheduler configuration bank with Wishbone slave, pending/applied copies and classifier
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module qsc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic apply_i,
  input wire logic req_valid_i,
  input wire logic [3:0] request_service_value_i,
  output qsc_pkg::qsc_class_t req_class_o,
  output logic [3:0] per_value_queue_priority_o,
  output logic [3:0] per_value_promotion_timeout_o,
  output logic timeout_promote_en_o,
  output logic row_hit_favour_o,
  output logic [5:0] row_streak_cap_o,
  output logic row_streak_cap_en_o,
  output logic result_valid_o,
  output logic [3:0] backlog_limit_o,
  output logic backlog_suppress_en_o,
  output logic [3:0] escalation_count_o,
  output logic [1:0] escalation_presc_o,
  output logic escalation_en_o,
  output logic [1:0] timeout_presc_o,
  output logic apply_done_o
);
  import qsc_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel, input logic [31:0] msk);
    logic [31:0] be;
    be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & msk;
    merge = (old & ~be) | (wd & be);
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  // ==========================================================
  // Pending and applied copies
  logic [31:0] p_hit_reg, p_hit_next, p_thr_reg, p_thr_next, p_esc_reg, p_esc_next;
  logic [31:0] p_plo_reg, p_plo_next, p_phi_reg, p_phi_next, p_tmo_reg, p_tmo_next;
  logic [31:0] p_tps_reg, p_tps_next;
  logic [31:0] a_hit_reg, a_hit_next, a_thr_reg, a_thr_next, a_esc_reg, a_esc_next;
  logic [31:0] a_plo_reg, a_plo_next, a_phi_reg, a_phi_next, a_tmo_reg, a_tmo_next;
  logic [31:0] a_tps_reg, a_tps_next;
  logic ack_reg, ack_next, done_reg, done_next;
  logic [31:0] dat_reg, dat_next;
  logic wr_now;

  always_comb begin
    // Write lands at the edge where the master samples ack
    wr_now = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    p_hit_next = p_hit_reg;
    p_thr_next = p_thr_reg;
    p_esc_next = p_esc_reg;
    p_plo_next = p_plo_reg;
    p_phi_next = p_phi_reg;
    p_tmo_next = p_tmo_reg;
    p_tps_next = p_tps_reg;
    if (wr_now && hit(wb_adr_i, OFF_HIT_STREAK)) begin
      p_hit_next = merge(p_hit_reg, wb_dat_i, wb_sel_i, MSK_HIT_STREAK);
    end
    if (wr_now && hit(wb_adr_i, OFF_CLASS_THR)) begin
      p_thr_next = merge(p_thr_reg, wb_dat_i, wb_sel_i, MSK_CLASS_THR);
    end
    if (wr_now && hit(wb_adr_i, OFF_ESCALATE)) begin
      p_esc_next = merge(p_esc_reg, wb_dat_i, wb_sel_i, MSK_ESCALATE);
    end
    if (wr_now && hit(wb_adr_i, OFF_PRIO_LO)) begin
      p_plo_next = merge(p_plo_reg, wb_dat_i, wb_sel_i, MSK_FULL);
    end
    if (wr_now && hit(wb_adr_i, OFF_PRIO_HI)) begin
      p_phi_next = merge(p_phi_reg, wb_dat_i, wb_sel_i, MSK_FULL);
    end
    if (wr_now && hit(wb_adr_i, OFF_TMO_LO)) begin
      p_tmo_next = merge(p_tmo_reg, wb_dat_i, wb_sel_i, MSK_FULL);
    end
    if (wr_now && hit(wb_adr_i, OFF_TMO_PRESC)) begin
      p_tps_next = merge(p_tps_reg, wb_dat_i, wb_sel_i, MSK_TMO_PRESC);
    end
    // Applied copies follow pending ones only on the apply command
    a_hit_next = apply_i ? p_hit_reg : a_hit_reg;
    a_thr_next = apply_i ? p_thr_reg : a_thr_reg;
    a_esc_next = apply_i ? p_esc_reg : a_esc_reg;
    a_plo_next = apply_i ? p_plo_reg : a_plo_reg;
    a_phi_next = apply_i ? p_phi_reg : a_phi_reg;
    a_tmo_next = apply_i ? p_tmo_reg : a_tmo_reg;
    a_tps_next = apply_i ? p_tps_reg : a_tps_reg;
    done_next = apply_i;
    // Bus answer one cycle after the request, unmapped reads return zero
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    dat_next = 32'h00000000;
    if (ack_next && !wb_we_i) begin
      if (hit(wb_adr_i, OFF_HIT_STREAK)) begin
        dat_next = p_hit_reg;
      end else if (hit(wb_adr_i, OFF_CLASS_THR)) begin
        dat_next = p_thr_reg;
      end else if (hit(wb_adr_i, OFF_ESCALATE)) begin
        dat_next = p_esc_reg;
      end else if (hit(wb_adr_i, OFF_PRIO_LO)) begin
        dat_next = p_plo_reg;
      end else if (hit(wb_adr_i, OFF_PRIO_HI)) begin
        dat_next = p_phi_reg;
      end else if (hit(wb_adr_i, OFF_TMO_LO)) begin
        dat_next = p_tmo_reg;
      end else if (hit(wb_adr_i, OFF_TMO_PRESC)) begin
        dat_next = p_tps_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_hit_reg <= RST_HIT_STREAK;
      p_thr_reg <= RST_CLASS_THR;
      p_esc_reg <= RST_ESCALATE;
      p_plo_reg <= RST_PRIO_LO;
      p_phi_reg <= RST_PRIO_HI;
      p_tmo_reg <= RST_TMO_LO;
      p_tps_reg <= RST_TMO_PRESC;
      a_hit_reg <= RST_HIT_STREAK;
      a_thr_reg <= RST_CLASS_THR;
      a_esc_reg <= RST_ESCALATE;
      a_plo_reg <= RST_PRIO_LO;
      a_phi_reg <= RST_PRIO_HI;
      a_tmo_reg <= RST_TMO_LO;
      a_tps_reg <= RST_TMO_PRESC;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      done_reg <= 1'b0;
    end else begin
      p_hit_reg <= p_hit_next;
      p_thr_reg <= p_thr_next;
      p_esc_reg <= p_esc_next;
      p_plo_reg <= p_plo_next;
      p_phi_reg <= p_phi_next;
      p_tmo_reg <= p_tmo_next;
      p_tps_reg <= p_tps_next;
      a_hit_reg <= a_hit_next;
      a_thr_reg <= a_thr_next;
      a_esc_reg <= a_esc_next;
      a_plo_reg <= a_plo_next;
      a_phi_reg <= a_phi_next;
      a_tmo_reg <= a_tmo_next;
      a_tps_reg <= a_tps_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      done_reg <= done_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign apply_done_o = done_reg;

  // ==========================================================
  // Scheduler-facing settings
  assign backlog_limit_o = a_esc_reg[BACKLOG_LSB +: NIB_W];
  assign backlog_suppress_en_o = (a_esc_reg[BACKLOG_LSB +: NIB_W] != 4'h0);
  assign escalation_count_o = a_esc_reg[ESC_CNT_LSB +: NIB_W];
  assign escalation_presc_o = a_esc_reg[ESC_PRESC_LSB +: PRESC_W];
  assign escalation_en_o = (a_esc_reg[ESC_CNT_LSB +: NIB_W] != 4'h0);
  assign timeout_presc_o = a_tps_reg[PRESC_W-1:0];

  // ==========================================================
  // Classifier
  qsc_cfg_if cfg_bus ();
  assign cfg_bus.hit_streak = a_hit_reg;
  assign cfg_bus.class_thr = a_thr_reg;
  assign cfg_bus.prio_lo = a_plo_reg;
  assign cfg_bus.prio_hi = a_phi_reg;
  assign cfg_bus.tmo_lo = a_tmo_reg;

  qsc_classify u_classify (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg(cfg_bus.dst),
    .req_valid_i(req_valid_i),
    .request_service_value_i(request_service_value_i),
    .req_class_o(req_class_o),
    .per_value_queue_priority_o(per_value_queue_priority_o),
    .per_value_promotion_timeout_o(per_value_promotion_timeout_o),
    .timeout_promote_en_o(timeout_promote_en_o),
    .row_hit_favour_o(row_hit_favour_o),
    .row_streak_cap_o(row_streak_cap_o),
    .row_streak_cap_en_o(row_streak_cap_en_o),
    .result_valid_o(result_valid_o)
  );

  // ==========================================================
  // Bus checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_bus_answers: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus request not answered in one cycle");
  chk_read_back: assert property (
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && hit(wb_adr_i, OFF_PRIO_LO)
    |=> wb_dat_o == $past(p_plo_reg))
    else $error("read data mismatch");
  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  chk_idle_data_zero: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside ack");
  chk_read_streak: assert property (
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && hit(wb_adr_i, OFF_HIT_STREAK)
    |=> wb_dat_o == $past(p_hit_reg))
    else $error("streak limit read data mismatch");
  chk_write_lands: assert property (
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i == 4'hf && hit(wb_adr_i, OFF_PRIO_HI)
    |=> p_phi_reg == $past(wb_dat_i))
    else $error("full word write did not land");
  chk_write_masked: assert property (
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i == 4'hf && hit(wb_adr_i, OFF_CLASS_THR)
    |=> p_thr_reg == ($past(wb_dat_i) & MSK_CLASS_THR))
    else $error("threshold write kept reserved bits");
  chk_reserved_zero: assert property (
    (p_hit_reg & ~MSK_HIT_STREAK) == 32'h00000000 && (p_esc_reg & ~MSK_ESCALATE) == 32'h00000000
    && (p_tps_reg & ~MSK_TMO_PRESC) == 32'h00000000)
    else $error("reserved bits held a value");

  // ==========================================================
  // Reset checks
  chk_identity_reset: assert property (
    $past(rst_i) |-> p_plo_reg == RST_PRIO_LO && p_phi_reg == RST_PRIO_HI)
    else $error("priority reset not identity");
  chk_presc_reset: assert property (
    $past(rst_i) |-> timeout_presc_o == 2'b01)
    else $error("timeout prescaler reset wrong");
  chk_reset_applied: assert property (
    $past(rst_i) |-> a_plo_reg == RST_PRIO_LO && a_phi_reg == RST_PRIO_HI && a_tps_reg == RST_TMO_PRESC)
    else $error("applied copies not at reset values");

  // ==========================================================
  // Apply checks
  chk_pending_hold: assert property (
    !apply_i |=> $stable(a_esc_reg) && $stable(a_plo_reg))
    else $error("applied copy changed without apply");
  chk_hold_rest: assert property (
    !apply_i |=> $stable(a_hit_reg) && $stable(a_thr_reg) && $stable(a_phi_reg) && $stable(a_tmo_reg)
    && $stable(a_tps_reg))
    else $error("applied setting changed without apply");
  chk_apply_copy: assert property (
    apply_i |=> a_thr_reg == $past(p_thr_reg) && apply_done_o)
    else $error("apply did not copy pending value");
  chk_apply_rest: assert property (
    apply_i |=> a_hit_reg == $past(p_hit_reg) && a_esc_reg == $past(p_esc_reg)
    && a_tmo_reg == $past(p_tmo_reg) && a_plo_reg == $past(p_plo_reg)
    && a_phi_reg == $past(p_phi_reg) && a_tps_reg == $past(p_tps_reg))
    else $error("apply did not copy every pending value");
  chk_done_pulse: assert property (
    !apply_i |=> !apply_done_o)
    else $error("apply done without apply");
  chk_tmo_presc_apply: assert property (
    apply_i |=> timeout_presc_o == $past(p_tps_reg[1:0]))
    else $error("timeout prescaler not applied");
  chk_escalate_apply: assert property (
    apply_i |=> escalation_count_o == $past(p_esc_reg[11:8])
    && backlog_limit_o == $past(p_esc_reg[19:16]))
    else $error("escalation settings not applied");

  // ==========================================================
  // Setting checks
  chk_backlog_off: assert property (
    backlog_suppress_en_o == (a_esc_reg[19:16] != 4'h0))
    else $error("backlog enable wrong");
  chk_escalate_off: assert property (
    escalation_count_o == 4'h0 |-> !escalation_en_o)
    else $error("zero escalation count still enabled");
  chk_escalate_on: assert property (
    escalation_count_o != 4'h0 |-> escalation_en_o)
    else $error("nonzero escalation count not enabled");

  // ==========================================================
  // Cover points
  cov_write_apply: cover property (wr_now ##[1:20] apply_i);
  cov_read_unmapped: cover property (wb_ack_o && !wb_we_i && wb_dat_o == 32'h00000000);
  cov_backlog_on: cover property (backlog_suppress_en_o);
endmodule

/* test/tb_qsc_top.sv */
// Self-checking testbench for the scheduler configuration bank
`timescale 1ns/1ps
module tb_qsc_top;
  import qsc_pkg::*;

  // ==========================================================
  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic apply_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic [3:0] request_service_value_i = 4'h0;
  qsc_class_t req_class_o;
  logic [3:0] per_value_queue_priority_o;
  logic [3:0] per_value_promotion_timeout_o;
  logic timeout_promote_en_o;
  logic row_hit_favour_o;
  logic [5:0] row_streak_cap_o;
  logic row_streak_cap_en_o;
  logic result_valid_o;
  logic [3:0] backlog_limit_o;
  logic backlog_suppress_en_o;
  logic [3:0] escalation_count_o;
  logic [1:0] escalation_presc_o;
  logic escalation_en_o;
  logic [1:0] timeout_presc_o;
  logic apply_done_o;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] offs [7] = '{OFF_HIT_STREAK, OFF_CLASS_THR, OFF_ESCALATE, OFF_PRIO_LO, OFF_PRIO_HI, OFF_TMO_LO,
                           OFF_TMO_PRESC};
  logic [31:0] rsts [7] = '{RST_HIT_STREAK, RST_CLASS_THR, RST_ESCALATE, RST_PRIO_LO, RST_PRIO_HI, RST_TMO_LO,
                            RST_TMO_PRESC};
  logic [31:0] msks [7] = '{MSK_HIT_STREAK, MSK_CLASS_THR, MSK_ESCALATE, MSK_FULL, MSK_FULL, MSK_FULL,
                            MSK_TMO_PRESC};
  logic [31:0] pv [7] = '{32'h00bf8005, 32'h00000a53, 32'h000f0f03, 32'h0123cdef, 32'h13579bdf, 32'h9000f0a1,
                          32'h00000002};
  logic [31:0] m [7];

  always #5 clk_i = ~clk_i;

  qsc_top qsc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .apply_i(apply_i), .req_valid_i(req_valid_i), .request_service_value_i(request_service_value_i),
    .req_class_o(req_class_o), .per_value_queue_priority_o(per_value_queue_priority_o),
    .per_value_promotion_timeout_o(per_value_promotion_timeout_o), .timeout_promote_en_o(timeout_promote_en_o),
    .row_hit_favour_o(row_hit_favour_o), .row_streak_cap_o(row_streak_cap_o),
    .row_streak_cap_en_o(row_streak_cap_en_o), .result_valid_o(result_valid_o), .backlog_limit_o(backlog_limit_o),
    .backlog_suppress_en_o(backlog_suppress_en_o), .escalation_count_o(escalation_count_o),
    .escalation_presc_o(escalation_presc_o), .escalation_en_o(escalation_en_o), .timeout_presc_o(timeout_presc_o),
    .apply_done_o(apply_done_o)
  );

  // ==========================================================
  // Shared tasks
  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                    input logic [31:0] e);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    if (!we) chk($sformatf("read_%h", a), e, wb_dat_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd_all(input logic [31:0] ex [7]);
    for (int i = 0; i < 7; i++) wb(1'b0, offs[i], 4'hf, 32'h0, ex[i]);
  endtask

  task automatic chk_sched();
    #1;
    chk("backlog_limit", {28'h0, m[2][19:16]}, {28'h0, backlog_limit_o});
    chk("backlog_en", {31'h0, m[2][19:16] != 4'h0}, {31'h0, backlog_suppress_en_o});
    chk("esc_count", {28'h0, m[2][11:8]}, {28'h0, escalation_count_o});
    chk("esc_en", {31'h0, m[2][11:8] != 4'h0}, {31'h0, escalation_en_o});
    chk("esc_presc", {30'h0, m[2][1:0]}, {30'h0, escalation_presc_o});
    chk("tmo_presc", {30'h0, m[6][1:0]}, {30'h0, timeout_presc_o});
  endtask

  task automatic apply_cmd();
    @(posedge clk_i);
    apply_i <= 1'b1;
    @(posedge clk_i);
    apply_i <= 1'b0;
    for (int i = 0; i < 7; i++) m[i] = m[i] & msks[i];
    chk_sched();
    chk("apply_done", 32'h1, {31'h0, apply_done_o});
    chk("valid_idle", 32'h0, {31'h0, result_valid_o});
  endtask

  task automatic classify(input logic [3:0] v);
    logic [1:0] c;
    logic [7:0] slot;
    logic [63:0] pr;
    logic [3:0] t;
    c = (v >= m[1][11:8]) ? 2'b11 : (v >= m[1][7:4]) ? 2'b10 : (v >= m[1][3:0]) ? 2'b01 : 2'b00;
    slot = m[0][8 * c +: 8];
    pr = {m[4], m[3]};
    t = v[3] ? 4'h0 : m[5][4 * v[2:0] +: 4];
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    request_service_value_i <= v;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    #1;
    chk("valid", 32'h1, {31'h0, result_valid_o});
    chk("apply_idle", 32'h0, {31'h0, apply_done_o});
    chk($sformatf("class_%h", v), {30'h0, c}, {30'h0, req_class_o});
    chk($sformatf("prio_%h", v), {28'h0, pr[4 * v +: 4]}, {28'h0, per_value_queue_priority_o});
    chk($sformatf("tmo_%h", v), {28'h0, t}, {28'h0, per_value_promotion_timeout_o});
    chk($sformatf("tmo_en_%h", v), {31'h0, t != 4'h0}, {31'h0, timeout_promote_en_o});
    chk($sformatf("favour_%h", v), {31'h0, slot[7]}, {31'h0, row_hit_favour_o});
    chk($sformatf("cap_%h", v), {26'h0, slot[5:0]}, {26'h0, row_streak_cap_o});
    chk($sformatf("cap_en_%h", v), {31'h0, slot[5:0] != 6'h0}, {31'h0, row_streak_cap_en_o});
  endtask

  // ==========================================================
  // Timeout
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles >= 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    m = rsts;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_sched();
    rd_all(rsts);
    wb(1'b0, 8'h50, 4'hf, 32'h0, 32'h0);
    for (int v = 0; v < 16; v++) classify(v[3:0]);
    for (int i = 0; i < 7; i++) wb(1'b1, offs[i], 4'hf, pv[i], 32'h0);
    rd_all(pv);
    classify(4'h4);
    chk_sched();
    m = pv;
    apply_cmd();
    for (int v = 0; v < 16; v++) classify(v[3:0]);
    wb(1'b1, OFF_PRIO_LO, 4'b0100, 32'h00550000, 32'h0);
    wb(1'b0, OFF_PRIO_LO, 4'hf, 32'h0, 32'h0155cdef);
    for (int i = 0; i < 3; i++) wb(1'b1, offs[i], 4'hf, 32'h0, 32'h0);
    m[0] = 32'h0;
    m[1] = 32'h0;
    m[2] = 32'h0;
    m[3] = 32'h0155cdef;
    apply_cmd();
    classify(4'h0);
    classify(4'h9);
    for (int i = 0; i < 7; i++) wb(1'b1, offs[i], 4'hf, 32'hffffffff, 32'h0);
    rd_all(msks);
    wb(1'b1, 8'h50, 4'hf, 32'hffffffff, 32'h0);
    wb(1'b0, 8'h50, 4'hf, 32'h0, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    m = rsts;
    chk_sched();
    rd_all(rsts);
    finish_test();
  end
endmodule
